/* design/acq_pkg.sv */
// Constants, field layout and state codes for the acquisition configuration block.
package acq_pkg;

  // ------------------------------------------------------------------
  // Register map and field layout
  // ------------------------------------------------------------------
  localparam logic [7:0]  ACQ_CONFIG_ADDR  = 8'h0C;   // Serial register address.
  localparam int          PRESCALE_LSB     = 12;      // Balance timer prescale field, 2 bits.
  localparam int          TIMER_LSB        = 8;       // Balance timeout count field, 4 bits.
  localparam int          AUX_LSB          = 0;       // Auxiliary settle count field, 6 bits.
  localparam int          PRESCALE_W       = 2;
  localparam int          TIMER_W          = 4;
  localparam int          AUX_W            = 6;
  localparam logic [15:0] ACQ_CONFIG_RESET = 16'h0000;  // Value after reset.
  localparam logic [15:0] ACQ_WRITE_MASK   = 16'h3F3F;  // Bits 15, 14, 7 and 6 stay zero.
  localparam int          BAL_CELLS        = 12;        // Number of discharge switches.

  // ------------------------------------------------------------------
  // Timing
  // ------------------------------------------------------------------
  localparam int CLK_MHZ            = 40;                // Core clock rate.
  localparam int TICK_TIME_S        = 1;                 // Base balance timer tick, seconds.
  localparam int TICK_CYCLES        = TICK_TIME_S * CLK_MHZ * 1000000;
  localparam int SETTLE_STEP_NS     = 5300;              // One settle count, 5.3 us.
  localparam int SETTLE_STEP_CYCLES = (SETTLE_STEP_NS * CLK_MHZ + 999) / 1000;

  // Base ticks per timer step for prescale codes 1 to 3; code 0 disables the timer.
  localparam logic [4:0] TICKS_CODE1 = 5'h01;   // 1 s steps.
  localparam logic [4:0] TICKS_CODE2 = 5'h04;   // 4 s steps.
  localparam logic [4:0] TICKS_CODE3 = 5'h10;   // 16 s steps.

  // ------------------------------------------------------------------
  // Auxiliary measurement sequencer states
  // ------------------------------------------------------------------
  typedef enum logic [2:0] {
    AUX_IDLE        = 3'b000,
    AUX_SETTLE_ONE  = 3'b001,
    AUX_CONVERT_ONE = 3'b010,
    AUX_SETTLE_TWO  = 3'b011,
    AUX_CONVERT_TWO = 3'b100
  } aux_state_t;

endpackage

/* design/settle_timer.sv */
// Programmable settle delay: (count + 1) steps of a fixed number of clock cycles.
`timescale 1ns/1ps
`default_nettype none
module settle_timer #(
  parameter int STEP_CYCLES = acq_pkg::SETTLE_STEP_CYCLES,
  parameter int COUNT_W     = acq_pkg::AUX_W
) (
  // Clock, reset, enable
  input  wire logic               core_clk,
  input  wire logic               reset,
  input  wire logic               ce,
  // Control
  input  wire logic               start,
  input  wire logic [COUNT_W-1:0] count,
  // Result
  output logic                    done
);
  import acq_pkg::*;

  localparam int CYC_W = (STEP_CYCLES > 1) ? $clog2(STEP_CYCLES) : 1;
  localparam logic [CYC_W-1:0] CYC_LAST = CYC_W'(STEP_CYCLES - 1);

  initial begin
    if (STEP_CYCLES < 1 || COUNT_W < 1) begin
      $error("settle_timer: step and count width must be at least one");
    end
  end

  logic               busy;        // A delay is running.
  logic [COUNT_W-1:0] steps;       // Whole steps still to run after this one.
  logic [CYC_W-1:0]   cyc;         // Cycles left in the current step.
  logic               next_busy;
  logic [COUNT_W-1:0] next_steps;
  logic [CYC_W-1:0]   next_cyc;
  logic               next_done;

  // Next-state logic; a new start restarts a running delay.
  always_comb begin
    next_busy  = busy;
    next_steps = steps;
    next_cyc   = cyc;
    next_done  = 1'b0;
    if (start) begin
      next_busy  = 1'b1;
      next_steps = count;
      next_cyc   = CYC_LAST;
    end else if (busy) begin
      if (cyc == '0) begin
        if (steps == '0) begin
          next_busy = 1'b0;
          next_done = 1'b1;
        end else begin
          next_steps = steps - 1'b1;
          next_cyc   = CYC_LAST;
        end
      end else begin
        next_cyc = cyc - 1'b1;
      end
    end
  end

  // State registers, frozen while the clock enable is low.
  always_ff @(posedge core_clk) begin
    if (reset) begin
      busy  <= 1'b0;
      steps <= '0;
      cyc   <= '0;
      done  <= 1'b0;
    end else if (ce) begin
      busy  <= next_busy;
      steps <= next_steps;
      cyc   <= next_cyc;
      done  <= next_done;
    end
  end

endmodule
`default_nettype wire

/* design/cell_balance_timeout_aux_settle.sv */
// Acquisition configuration register, balance watchdog and auxiliary settle sequencer.
`timescale 1ns/1ps
`default_nettype none
module cell_balance_timeout_aux_settle #(
  parameter int TICK_CYCLES = acq_pkg::TICK_CYCLES   // Cycles per base one-second tick.
) (
  // Clock, reset, enable
  input  wire logic                          core_clk,
  input  wire logic                          reset,
  input  wire logic                          ce,
  // Register access from the serial command decoder
  input  wire logic                          reg_wr,
  input  wire logic                          reg_rd,
  input  wire logic [7:0]                    reg_addr,
  input  wire logic [15:0]                   reg_wdata,
  input  wire logic                          bcast_read,
  input  wire logic                          bcast_latch,
  output logic [15:0]                        reg_rdata,
  output logic                               reg_rdata_valid,
  // Cell discharge control
  input  wire logic [acq_pkg::BAL_CELLS-1:0] cell_discharge_enable,
  input  wire logic                          die_overtemp,
  output logic [acq_pkg::BAL_CELLS-1:0]      cell_discharge_switch,
  output logic                               balance_expired,
  // Auxiliary measurement sequence
  input  wire logic                          measure_start,
  input  wire logic                          aux_input_one_en,
  input  wire logic                          aux_input_two_en,
  input  wire logic                          aux_conv_done,
  output logic                               aux_convert_req,
  output logic                               aux_convert_sel,
  output logic                               thermistor_bias_out,
  output logic                               aux_seq_busy
);
  import acq_pkg::*;

  // ------------------------------------------------------------------
  // Elaboration checks and local constants
  // ------------------------------------------------------------------
  localparam int SEC_W = (TICK_CYCLES > 1) ? $clog2(TICK_CYCLES) : 1;
  localparam logic [SEC_W-1:0] SEC_LAST = SEC_W'(TICK_CYCLES - 1);

  initial begin
    if (TICK_CYCLES < 1) begin
      $error("cell_balance_timeout_aux_settle: TICK_CYCLES must be at least one");
    end
  end

  // Base ticks per timer step for a prescale code; zero means disabled.
  function automatic logic [4:0] prescale_ticks(input logic [PRESCALE_W-1:0] code);
    case (code)
      2'b01:   prescale_ticks = TICKS_CODE1;
      2'b10:   prescale_ticks = TICKS_CODE2;
      2'b11:   prescale_ticks = TICKS_CODE3;
      default: prescale_ticks = 5'h00;
    endcase
  endfunction

  // ------------------------------------------------------------------
  // Overtemperature input synchroniser
  // ------------------------------------------------------------------
  logic ot_meta;   // First stage, read only by the second stage.
  logic ot_sync;   // Synchronised overtemperature level.

  // The detector is asynchronous to the core clock, so it passes two flops.
  always_ff @(posedge core_clk) begin
    if (reset) begin
      ot_meta <= 1'b0;
      ot_sync <= 1'b0;
    end else if (ce) begin
      ot_meta <= die_overtemp;
      ot_sync <= ot_meta;
    end
  end

  // ------------------------------------------------------------------
  // Register and balance watchdog
  // ------------------------------------------------------------------
  logic [PRESCALE_W-1:0]  prescale;        // Balance timer prescale code.
  logic [TIMER_W-1:0]     timeout_count;   // Live balance timeout count.
  logic [AUX_W-1:0]       settle_count;    // Auxiliary settle count.
  logic [TIMER_W-1:0]     count_snap;      // Count captured for a broadcast read.
  logic [SEC_W-1:0]       sec_cnt;         // Cycles left in the current base tick.
  logic [4:0]             tick_cnt;        // Base ticks counted in the current step.
  logic [PRESCALE_W-1:0]  next_prescale;
  logic [TIMER_W-1:0]     next_timeout_count;
  logic [AUX_W-1:0]       next_settle_count;
  logic [TIMER_W-1:0]     next_count_snap;
  logic [SEC_W-1:0]       next_sec_cnt;
  logic [4:0]             next_tick_cnt;
  logic [15:0]            next_reg_rdata;
  logic                   next_reg_rdata_valid;
  logic [BAL_CELLS-1:0]   next_switch;
  logic                   next_expired;
  logic                   hit_wr;
  logic                   hit_rd;
  logic [15:0]            wr_bits;
  logic [4:0]             step_ticks;

  // Next values for the register, the step dividers and the switch outputs.
  always_comb begin
    hit_wr     = reg_wr && (reg_addr == ACQ_CONFIG_ADDR);
    hit_rd     = reg_rd && (reg_addr == ACQ_CONFIG_ADDR);
    wr_bits    = reg_wdata & ACQ_WRITE_MASK;
    step_ticks = prescale_ticks(prescale);
    next_prescale      = prescale;
    next_timeout_count = timeout_count;
    next_settle_count  = settle_count;
    next_sec_cnt       = sec_cnt;
    next_tick_cnt      = tick_cnt;
    next_count_snap    = count_snap;
    if (hit_wr) begin
      // A write reloads the count and restarts the step, so the host always
      // gets one full step per count; a write beats a same-cycle decrement.
      next_prescale      = wr_bits[PRESCALE_LSB +: PRESCALE_W];
      next_timeout_count = wr_bits[TIMER_LSB +: TIMER_W];
      next_settle_count  = wr_bits[AUX_LSB +: AUX_W];
      next_sec_cnt       = SEC_LAST;
      next_tick_cnt      = 5'h00;
    end else if (step_ticks == 5'h00) begin
      next_sec_cnt  = SEC_LAST;
      next_tick_cnt = 5'h00;
    end else if (timeout_count != '0) begin
      if (sec_cnt == '0) begin
        next_sec_cnt = SEC_LAST;
        if (tick_cnt == step_ticks - 5'h01) begin
          next_tick_cnt      = 5'h00;
          next_timeout_count = timeout_count - 1'b1;
        end else begin
          next_tick_cnt = tick_cnt + 5'h01;
        end
      end else begin
        next_sec_cnt = sec_cnt - 1'b1;
      end
    end
    if (bcast_latch) begin
      next_count_snap = timeout_count;
    end
    // Read data; reserved bits and other addresses read zero.
    next_reg_rdata       = 16'h0000;
    next_reg_rdata_valid = hit_rd;
    if (hit_rd) begin
      next_reg_rdata[PRESCALE_LSB +: PRESCALE_W] = prescale;
      next_reg_rdata[TIMER_LSB +: TIMER_W]       = bcast_read ? count_snap : timeout_count;
      next_reg_rdata[AUX_LSB +: AUX_W]           = settle_count;
    end
    next_expired = (prescale_ticks(next_prescale) != 5'h00) && (next_timeout_count == '0);
    next_switch  = (ot_sync || next_expired) ? '0 : cell_discharge_enable;
  end

  // Register the configuration, counters and registered outputs.
  always_ff @(posedge core_clk) begin
    if (reset) begin
      prescale              <= ACQ_CONFIG_RESET[PRESCALE_LSB +: PRESCALE_W];
      timeout_count         <= ACQ_CONFIG_RESET[TIMER_LSB +: TIMER_W];
      settle_count          <= ACQ_CONFIG_RESET[AUX_LSB +: AUX_W];
      count_snap            <= '0;
      sec_cnt               <= SEC_LAST;
      tick_cnt              <= 5'h00;
      reg_rdata             <= 16'h0000;
      reg_rdata_valid       <= 1'b0;
      cell_discharge_switch <= '0;
      balance_expired       <= 1'b0;
    end else if (ce) begin
      prescale              <= next_prescale;
      timeout_count         <= next_timeout_count;
      settle_count          <= next_settle_count;
      count_snap            <= next_count_snap;
      sec_cnt               <= next_sec_cnt;
      tick_cnt              <= next_tick_cnt;
      reg_rdata             <= next_reg_rdata;
      reg_rdata_valid       <= next_reg_rdata_valid;
      cell_discharge_switch <= next_switch;
      balance_expired       <= next_expired;
    end
  end

  // ------------------------------------------------------------------
  // Auxiliary measurement sequencer
  // ------------------------------------------------------------------
  aux_state_t aux_state;        // Sequencer state.
  aux_state_t next_aux_state;
  logic       two_en;           // Second channel enable held for the sequence.
  logic       next_two_en;
  logic       settle_start;     // Starts one full settle delay.
  logic       settle_done;      // Settle delay finished.
  logic       next_convert_req;
  logic       next_convert_sel;
  logic       next_bias;

  // (count + 1) * 5.3 us
  settle_timer #(
    .STEP_CYCLES (SETTLE_STEP_CYCLES),
    .COUNT_W     (AUX_W)
  ) u_settle (
    .core_clk (core_clk),
    .reset    (reset),
    .ce       (ce),
    .start    (settle_start),
    .count    (settle_count),
    .done     (settle_done)
  );

  // Sequencer next state; a start while busy is ignored.
  always_comb begin
    next_aux_state   = aux_state;
    next_two_en      = two_en;
    settle_start     = 1'b0;
    next_convert_req = 1'b0;
    next_convert_sel = aux_convert_sel;
    case (aux_state)
      AUX_IDLE: begin
        if (measure_start) begin
          next_two_en = aux_input_two_en;
          if (aux_input_one_en) begin
            settle_start   = 1'b1;
            next_aux_state = AUX_SETTLE_ONE;
          end else if (aux_input_two_en) begin
            settle_start   = 1'b1;
            next_aux_state = AUX_SETTLE_TWO;
          end
        end
      end
      AUX_SETTLE_ONE: begin
        if (settle_done) begin
          next_convert_req = 1'b1;
          next_convert_sel = 1'b0;
          next_aux_state   = AUX_CONVERT_ONE;
        end
      end
      AUX_CONVERT_ONE: begin
        if (aux_conv_done) begin
          if (two_en) begin
            settle_start   = 1'b1;
            next_aux_state = AUX_SETTLE_TWO;
          end else begin
            next_aux_state = AUX_IDLE;
          end
        end
      end
      AUX_SETTLE_TWO: begin
        if (settle_done) begin
          next_convert_req = 1'b1;
          next_convert_sel = 1'b1;
          next_aux_state   = AUX_CONVERT_TWO;
        end
      end
      AUX_CONVERT_TWO: begin
        if (aux_conv_done) begin
          next_aux_state = AUX_IDLE;
        end
      end
      default: begin
        next_aux_state = AUX_IDLE;
      end
    endcase
    next_bias = (next_aux_state != AUX_IDLE);
  end

  // Sequencer registers and its registered outputs.
  always_ff @(posedge core_clk) begin
    if (reset) begin
      aux_state           <= AUX_IDLE;
      two_en              <= 1'b0;
      aux_convert_req     <= 1'b0;
      aux_convert_sel     <= 1'b0;
      thermistor_bias_out <= 1'b0;
      aux_seq_busy        <= 1'b0;
    end else if (ce) begin
      aux_state           <= next_aux_state;
      two_en              <= next_two_en;
      aux_convert_req     <= next_convert_req;
      aux_convert_sel     <= next_convert_sel;
      thermistor_bias_out <= next_bias;
      aux_seq_busy        <= next_bias;
    end
  end

endmodule
`default_nettype wire

/* dv/cbt_checker_properties.sv */
// Port-level checker for the acquisition configuration block.
`timescale 1ns/1ps
`default_nettype none
module cbt_checker
  import acq_pkg::*;
#(
  parameter int TICK_CYCLES = acq_pkg::TICK_CYCLES  // Unused; kept in step with the design.
) (
  // Clock and control inputs
  input wire logic                 core_clk, reset, ce, reg_wr, reg_rd, bcast_read,
  input wire logic                 bcast_latch, die_overtemp, measure_start,
  input wire logic                 aux_input_one_en, aux_input_two_en, aux_conv_done,
  input wire logic [7:0]           reg_addr,
  input wire logic [15:0]          reg_wdata,
  input wire logic [BAL_CELLS-1:0] cell_discharge_enable,
  // Design outputs
  input wire logic [15:0]          reg_rdata,
  input wire logic [BAL_CELLS-1:0] cell_discharge_switch,
  input wire logic                 reg_rdata_valid, balance_expired, aux_convert_req,
  input wire logic                 aux_convert_sel, thermistor_bias_out, aux_seq_busy
);
  // ------------------------------------------------------------------
  // Settle age: cycles since a sequence start or a finished conversion.
  // ------------------------------------------------------------------
  logic        hit_wr;
  logic [15:0] since;
  logic [15:0] next_since;
  logic [5:0]  aux_set;   // Settle count last written by the host.
  assign hit_wr = ce && reg_wr && reg_addr == ACQ_CONFIG_ADDR;
  // Saturates so that a long idle spell cannot wrap into a false short age.
  always_comb begin
    next_since = since + 16'h0001;
    if ((measure_start && !aux_seq_busy) || aux_conv_done) next_since = 16'h0000;
    else if (since == 16'hFFFF) next_since = since;
  end
  always_ff @(posedge core_clk) begin
    since <= reset ? 16'h0000 : next_since;
    if (reset) aux_set <= 6'h00;
    else if (hit_wr) aux_set <= reg_wdata[5:0];
  end
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (reset);
  property p_rsvd; reg_rdata_valid |-> (reg_rdata & ~ACQ_WRITE_MASK) == 16'h0000; endproperty
  a_rsvd: assert property (p_rsvd) else $error("reserved bits read nonzero");
  property p_rd_ans; ce && reg_rd |=> reg_rdata_valid == ($past(reg_addr) == ACQ_CONFIG_ADDR);
  endproperty
  a_rd_ans: assert property (p_rd_ans) else $error("read answer wrong");
  property p_off; hit_wr && reg_wdata[13:12] == 2'b00 |=> !balance_expired; endproperty
  a_off: assert property (p_off) else $error("expiry with timeout disabled");
  property p_zero; hit_wr && reg_wdata[13:12] != 2'b00 && reg_wdata[11:8] == 4'h0
    |=> balance_expired; endproperty
  a_zero: assert property (p_zero) else $error("zero count not expired");
  property p_exp_off; balance_expired && $past(balance_expired)
    |-> cell_discharge_switch == 12'h000; endproperty
  a_exp_off: assert property (p_exp_off) else $error("switch on after expiry");
  property p_sw_en; (cell_discharge_switch & ~$past(cell_discharge_enable)) == 12'h000;
  endproperty
  a_sw_en: assert property (p_sw_en) else $error("switch on without enable");
  property p_otemp; die_overtemp [*4] |=> cell_discharge_switch == 12'h000; endproperty
  a_otemp: assert property (p_otemp) else $error("switch on while overheated");
  property p_bias; $rose(thermistor_bias_out) |-> $past(measure_start, 1) || $past(measure_start, 2);
  endproperty
  a_bias: assert property (p_bias) else $error("bias without start");
  property p_req; aux_convert_req |-> thermistor_bias_out ##1 !aux_convert_req; endproperty
  a_req: assert property (p_req) else $error("convert request malformed");
  property p_settle; aux_convert_req
    |-> since >= (16'(aux_set) + 16'h0001) * 16'(SETTLE_STEP_CYCLES); endproperty
  a_settle: assert property (p_settle) else $error("settle cut short");
  c_two: cover property (aux_convert_req && aux_convert_sel);
  c_exp: cover property ($rose(balance_expired));
  c_bcast: cover property (ce && reg_rd && bcast_read);
endmodule
bind cell_balance_timeout_aux_settle cbt_checker #(.TICK_CYCLES(TICK_CYCLES)) u_chk (
  .core_clk, .reset, .ce, .reg_wr, .reg_rd, .bcast_read, .bcast_latch, .die_overtemp,
  .measure_start, .aux_input_one_en, .aux_input_two_en, .aux_conv_done, .reg_addr,
  .reg_wdata, .cell_discharge_enable, .reg_rdata, .cell_discharge_switch,
  .reg_rdata_valid, .balance_expired, .aux_convert_req, .aux_convert_sel,
  .thermistor_bias_out, .aux_seq_busy);
`default_nettype wire

/* dv/adc_model.sv */
// Conversion engine model: answers each convert request after a set delay.
`timescale 1ns/1ps
`default_nettype none
module adc_model (
  input wire logic       core_clk,
  input wire logic       reset,
  input wire logic       aux_convert_req,
  input wire logic [7:0] conv_delay,
  output logic           aux_conv_done
);
  logic [7:0] left;  // Cycles still to convert.
  logic       busy;  // A conversion is running.
  // Done is a single pulse, so a slow delay tests the sequencer's patience.
  always @(posedge core_clk) begin
    aux_conv_done <= 1'b0;
    if (reset) begin
      busy <= 1'b0;
      left <= 8'h00;
    end else if (aux_convert_req) begin
      busy <= 1'b1;
      left <= conv_delay;
    end else if (busy && left == 8'h00) begin
      aux_conv_done <= 1'b1;
      busy <= 1'b0;
    end else if (busy) begin
      left <= left - 8'h01;
    end
  end
endmodule
`default_nettype wire

/* dv/cell_balance_timeout_aux_settle_tb_top.sv */
// Self-checking testbench for the acquisition configuration block.
`timescale 1ns/1ps
`default_nettype none
module cell_balance_timeout_aux_settle_tb_top;
  import acq_pkg::*;
  localparam int TICKS = 20;  // Shortened one-second tick.
  logic core_clk = 1'b0, reset = 1'b1, ce = 1'b1, reg_wr = 1'b0, reg_rd = 1'b0;
  logic bcast_read = 1'b0, bcast_latch = 1'b0, die_overtemp = 1'b0, measure_start = 1'b0;
  logic aux_input_one_en = 1'b0, aux_input_two_en = 1'b0, aux_conv_done, balance_expired;
  logic reg_rdata_valid, aux_convert_req, aux_convert_sel, thermistor_bias_out, aux_seq_busy;
  logic [7:0]  reg_addr = 8'h00, conv_delay = 8'h03;
  logic [15:0] reg_wdata = 16'h0000, reg_rdata;
  logic [11:0] cell_discharge_enable = 12'h000, cell_discharge_switch;
  logic [16:0] r;
  int err_total = 0, n_checks = 0;
  always #12.5 core_clk = ~core_clk;
  cell_balance_timeout_aux_settle #(.TICK_CYCLES(TICKS)) uut (.core_clk, .reset, .ce,
    .reg_wr, .reg_rd, .reg_addr, .reg_wdata, .bcast_read, .bcast_latch, .reg_rdata,
    .reg_rdata_valid, .cell_discharge_enable, .die_overtemp, .cell_discharge_switch,
    .balance_expired, .measure_start, .aux_input_one_en, .aux_input_two_en, .aux_conv_done,
    .aux_convert_req, .aux_convert_sel, .thermistor_bias_out, .aux_seq_busy);
  adc_model adc (.core_clk, .reset, .aux_convert_req, .conv_delay, .aux_conv_done);
  task automatic check(string what, logic [16:0] seen, logic [16:0] exp);
    n_checks++;
    if (seen !== exp) begin
      err_total++;
      $display("wrong value %s: expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic cyc(int n);
    repeat (n) @(negedge core_clk);
  endtask
  task automatic wr(logic [7:0] a, logic [15:0] d);
    @(negedge core_clk);
    reg_wr = 1'b1;
    reg_addr = a;
    reg_wdata = d;
    @(negedge core_clk);
    reg_wr = 1'b0;
  endtask
  // Read answer is sampled at the falling edge after the taking edge, with valid on top.
  task automatic rd(logic [7:0] a, logic b);
    @(negedge core_clk);
    reg_rd = 1'b1;
    reg_addr = a;
    bcast_read = b;
    @(negedge core_clk);
    reg_rd = 1'b0;
    bcast_read = 1'b0;
    r = {reg_rdata_valid, reg_rdata};
  endtask
  task automatic t_regs();
    rd(ACQ_CONFIG_ADDR, 1'b0);
    check("reset word", r, 17'h10000);
    wr(ACQ_CONFIG_ADDR, 16'hFFFF);
    rd(ACQ_CONFIG_ADDR, 1'b0);
    check("reserved bits", r, 17'h13F3F);
    wr(8'h0D, 16'h0000);
    rd(ACQ_CONFIG_ADDR, 1'b0);
    check("unmapped write", r, 17'h13F3F);
    rd(8'h0D, 1'b0);
    check("unmapped read", r, 17'h00000);
    $display("test done: registers");
  endtask
  task automatic t_nolimit();
    wr(ACQ_CONFIG_ADDR, 16'h0000);
    cell_discharge_enable = 12'hA5A;
    cyc(100);
    check("no limit expiry", 17'(balance_expired), 17'h0);
    check("no limit switches", 17'(cell_discharge_switch), 17'hA5A);
    die_overtemp = 1'b1;
    cyc(5);
    check("overheat switches", 17'(cell_discharge_switch), 17'h0);
    die_overtemp = 1'b0;
    cyc(5);
    check("cooled switches", 17'(cell_discharge_switch), 17'hA5A);
    // Turning the timeout on with a zero count must expire at once.
    wr(ACQ_CONFIG_ADDR, 16'h1000);
    check("zero count expiry", 17'(balance_expired), 17'h1);
    check("zero count switches", 17'(cell_discharge_switch), 17'h0);
    $display("test done: no limit");
  endtask
  task automatic t_reload();
    cell_discharge_enable = 12'hFFF;
    wr(ACQ_CONFIG_ADDR, 16'h1100);
    cyc(TICKS - 6);
    wr(ACQ_CONFIG_ADDR, 16'h1100);
    cyc(TICKS - 6);
    check("reloaded switches", 17'(cell_discharge_switch), 17'hFFF);
    $display("test done: reload");
  endtask
  task automatic t_bcast();
    wr(ACQ_CONFIG_ADDR, 16'h1500);
    // Clock enable low freezes the step divider, so no step is lost or gained.
    ce = 1'b0;
    cyc(40);
    ce = 1'b1;
    cyc(2 * TICKS + 5);
    bcast_latch = 1'b1;
    cyc(1);
    bcast_latch = 1'b0;
    cyc(TICKS);
    rd(ACQ_CONFIG_ADDR, 1'b1);
    check("latched count", r, 17'h11300);
    rd(ACQ_CONFIG_ADDR, 1'b0);
    check("live count", r, 17'h11200);
    $display("test done: broadcast latch");
  endtask
  task automatic t_expire(logic [1:0] code);
    int n;
    int step;
    step = TICKS * (code == 2'b01 ? 1 : code == 2'b10 ? 4 : 16);
    cell_discharge_enable = 12'hFFF;
    wr(ACQ_CONFIG_ADDR, {2'b00, code, 4'h2, 8'h00});
    cyc(2);
    check("running switches", 17'(cell_discharge_switch), 17'hFFF);
    n = 2;
    while (balance_expired !== 1'b1 && n < 40 * step) begin
      cyc(1);
      n++;
    end
    check("expiry time", 17'(n >= 2 * step && n <= 2 * step + 3), 17'h1);
    check("expired switches", 17'(cell_discharge_switch), 17'h0);
    $display("test done: expiry code %0d", code);
  endtask
  task automatic t_aux(logic [5:0] s, logic e1, logic e2);
    int n;
    int lim;
    lim = (int'(s) + 1) * SETTLE_STEP_CYCLES;
    wr(ACQ_CONFIG_ADDR, {10'h000, s});
    aux_input_one_en = e1;
    aux_input_two_en = e2;
    @(negedge core_clk);
    measure_start = 1'b1;
    @(negedge core_clk);
    measure_start = 1'b0;
    cyc(1);
    check("bias on", 17'(thermistor_bias_out), 17'h1);
    n = 2;
    while (aux_convert_req !== 1'b1 && n < 20000) begin
      cyc(1);
      n++;
    end
    check("first settle", 17'(n >= lim && n <= lim + 4), 17'h1);
    check("first channel", 17'(aux_convert_sel), 17'(!e1));
    if (e1 && e2) begin
      cyc(1);
      n = 1;
      while (aux_convert_req !== 1'b1 && n < 20000) begin
        cyc(1);
        n++;
      end
      check("second settle", 17'(n > lim && n <= lim + int'(conv_delay) + 8), 17'h1);
      check("second channel", 17'(aux_convert_sel), 17'h1);
    end
    cyc(int'(conv_delay) + 5);
    check("bias off", 17'(thermistor_bias_out), 17'h0);
    $display("test done: settle %0d", s);
  endtask
  task automatic stop_test();
    $display("checks %0d mismatches %0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  initial begin
    repeat (6) @(negedge core_clk);
    reset = 1'b0;
    t_regs();
    t_nolimit();
    t_reload();
    t_bcast();
    for (int c = 1; c < 4; c++) t_expire(2'(c));
    t_aux(6'd0, 1'b1, 1'b1);
    conv_delay = 8'd40;
    t_aux(6'd63, 1'b1, 1'b1);
    t_aux(6'd1, 1'b1, 1'b0);
    t_aux(6'd2, 1'b0, 1'b1);
    stop_test();
  end
  // Watchdog sized well beyond the longest expected run.
  initial begin
    #2500000;
    err_total++;
    stop_test();
  end
endmodule
`default_nettype wire
